// ---- abc_top.sv ----
// Purpose: boundary-scan cells between the digital logic and the analog converter
// Assumes: tester pins are asynchronous; APB master on the system clock
// Notes: in extest the update stage drives the converter, else the APB registers do
//
// The APB slave port and the register offsets were decided locally.

`timescale 1ns/1ps

module abc_top
    import abc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // test access port data register side
    input wire logic tck,
    input wire logic tdi,
    input wire logic capture_dr,
    input wire logic shift_dr,
    input wire logic update_dr,
    input wire logic extest,
    output logic tdo,
    // comparator result from the converter
    input wire logic comp_in,
    // converter control inputs
    output logic aclk,
    output logic gain_path_en,
    output logic bandgap_neg_en,
    output logic conv_power_on,
    output logic amp_power_on,
    output logic gain_bypass_sel,
    output logic gain_x10_en,
    output logic gain_x20_en,
    output logic neg_input_ground_en,
    output logic hold,
    output logic bandgap_ref_en,
    output logic input_mux_sel_b3,
    output logic input_mux_sel_b4,
    output logic input_mux_sel_b5,
    output logic input_mux_sel_b6,
    output logic input_mux_sel_b7,
    output logic [DAC_W-1:0] dac_code
);

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic tck_d;
        abc_apb_st_t apb_st;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic [CTRL_W-1:0] ctrl;
        logic [DAC_W-1:0] dac;
        logic [N_IN-1:0] drive;
        logic [SETTLE_CNT_W-1:0] settle_cnt;
        logic settled;
    } abc_top_st_t;

    abc_top_st_t r;
    abc_top_st_t r_nxt;

    logic [N_CELL-1:0] cell_par;
    logic [N_CELL-1:0] cell_upd;
    logic cell_tdo;
    logic tck_rise;
    logic tck_fall;
    logic ext_mode;
    logic comp_raw;
    logic comp_seen;

    // register decode, shared by the read path and the write commit
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        reg_hit = (a[ADDR_W-1:2] == off[7:2]);
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = reg_hit(a, OFF_CTRL) || reg_hit(a, OFF_DAC)
            || reg_hit(a, OFF_STATUS) || reg_hit(a, OFF_SCAN_UPD);
    endfunction

    // edges only ever look at the second synchroniser stage
    assign tck_rise = r.sync2[S_TCK] && !r.tck_d;
    assign tck_fall = !r.sync2[S_TCK] && r.tck_d;
    assign ext_mode = r.sync2[S_EXTEST];
    assign comp_raw = r.sync2[S_COMP];

    // the capture stage sees what the logic drives and what the comparator returns
    assign cell_par = {r.dac, r.ctrl, comp_raw};

    abc_scan_reg #(
        .N(N_CELL),
        .UPD_RST(CELL_RST)
    ) u_cells (
        .clock(clock),
        .reset(reset),
        .tck_rise(tck_rise),
        .tck_fall(tck_fall),
        .capture(r.sync2[S_CAP]),
        .shift(r.sync2[S_SHIFT]),
        .update(r.sync2[S_UPD]),
        .tdi(r.sync2[S_TDI]),
        .par_in(cell_par),
        .scan_out(cell_tdo),
        .upd_out(cell_upd)
    );

    // in extest the logic side sees the comparator value held in its update stage
    assign comp_seen = ext_mode ? cell_upd[0] : comp_raw;

    always_comb
    begin
        r_nxt = r;
        r_nxt.sync1 = {comp_in, extest, update_dr, shift_dr, capture_dr, tdi, tck};
        r_nxt.sync2 = r.sync1;
        r_nxt.tck_d = r.sync2[S_TCK];

        // converter inputs: update stage in extest, else the software registers
        if (ext_mode)
        begin
            r_nxt.drive = cell_upd[N_CELL-1:1];
        end
        else
        begin
            r_nxt.drive = {r.dac, r.ctrl};
        end

        // converter settle tracking; the tester may still run a dummy conversion instead
        if (!r.drive[B_CONV_PWR])
        begin
            r_nxt.settle_cnt = '0;
            r_nxt.settled = 1'b0;
        end
        else if (!r.settled)
        begin
            if (r.settle_cnt == SETTLE_CNT_W'(CONV_SETTLE_CYC - 1))
            begin
                r_nxt.settled = 1'b1;
            end
            else
            begin
                r_nxt.settle_cnt = r.settle_cnt + SETTLE_CNT_W'(1);
            end
        end

        // apb: answer one cycle after the access phase starts
        case (r.apb_st)
            APB_IDLE:
            begin
                r_nxt.pready = 1'b0;
                r_nxt.pslverr = 1'b0;
                if (psel && penable)
                begin
                    r_nxt.apb_st = APB_RESP;
                    r_nxt.pready = 1'b1;
                    r_nxt.pslverr = !addr_mapped(paddr);
                    r_nxt.prdata = '0;
                    if (!pwrite)
                    begin
                        if (reg_hit(paddr, OFF_CTRL))
                        begin
                            r_nxt.prdata = {16'h0000, r.ctrl};
                        end
                        else if (reg_hit(paddr, OFF_DAC))
                        begin
                            r_nxt.prdata = {22'h000000, r.dac};
                        end
                        else if (reg_hit(paddr, OFF_STATUS))
                        begin
                            r_nxt.prdata[ST_COMP] = comp_seen;
                            r_nxt.prdata[ST_EXTEST] = ext_mode;
                            r_nxt.prdata[ST_COMP_RAW] = comp_raw;
                            r_nxt.prdata[ST_SETTLED] = r.settled;
                        end
                        else if (reg_hit(paddr, OFF_SCAN_UPD))
                        begin
                            r_nxt.prdata = {6'h00, cell_upd[N_CELL-1:1]};
                        end
                    end
                end
            end
            APB_RESP:
            begin
                // the write lands on the edge where the master samples pready
                if (pwrite && psel && penable)
                begin
                    if (reg_hit(paddr, OFF_CTRL))
                    begin
                        r_nxt.ctrl = pwdata[CTRL_W-1:0];
                    end
                    else if (reg_hit(paddr, OFF_DAC))
                    begin
                        r_nxt.dac = pwdata[DAC_W-1:0];
                    end
                end
                r_nxt.apb_st = APB_IDLE;
                r_nxt.pready = 1'b0;
                r_nxt.pslverr = 1'b0;
            end
            default:
            begin
                r_nxt.apb_st = APB_IDLE;
                r_nxt.pready = 1'b0;
                r_nxt.pslverr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            r.sync1 <= '0;
            r.sync2 <= '0;
            r.tck_d <= 1'b0;
            r.apb_st <= APB_IDLE;
            r.prdata <= '0;
            r.pready <= 1'b0;
            r.pslverr <= 1'b0;
            r.ctrl <= CTRL_RST;
            r.dac <= DAC_RST;
            r.drive <= IDLE_VEC;
            r.settle_cnt <= '0;
            r.settled <= 1'b0;
        end
        else
        begin
            r <= r_nxt;
        end
    end

    // outputs, each straight from a flop
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign tdo = cell_tdo;

    // the gain clock is only passed through; its timing is the tester's business
    assign aclk = r.drive[B_ACLK];
    assign gain_path_en = r.drive[B_GAIN_PATH];
    assign bandgap_neg_en = r.drive[B_BG_NEG];
    assign conv_power_on = r.drive[B_CONV_PWR];
    assign amp_power_on = r.drive[B_AMP_PWR];
    assign gain_bypass_sel = r.drive[B_BYPASS];
    assign gain_x10_en = r.drive[B_X10];
    assign gain_x20_en = r.drive[B_X20];
    assign neg_input_ground_en = r.drive[B_GND];
    assign hold = r.drive[B_HOLD];
    assign bandgap_ref_en = r.drive[B_REF];
    assign input_mux_sel_b3 = r.drive[B_MUX3];
    assign input_mux_sel_b4 = r.drive[B_MUX4];
    assign input_mux_sel_b5 = r.drive[B_MUX5];
    assign input_mux_sel_b6 = r.drive[B_MUX6];
    assign input_mux_sel_b7 = r.drive[B_MUX7];
    assign dac_code = r.drive[N_IN-1:B_DAC_LO];

endmodule

// ---- abc_scan_reg.sv ----
// Purpose: shared constants for the converter scan cells, and the scan register itself
// Assumes: one system clock; tck edges arrive as one-cycle strobes from the top
// Notes: each bit of the register is one general boundary-scan cell (shift and update stage)

`timescale 1ns/1ps

package abc_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_SETTLE_NS = 200;
    localparam int CONV_SETTLE_CYC = (CONV_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CNT_W = 4;

    // widths
    localparam int N_IN = 26;
    localparam int N_CELL = 27;
    localparam int CTRL_W = 16;
    localparam int DAC_W = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DAC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_SCAN_UPD = 8'h0C;

    // positions inside the converter input vector
    localparam int B_ACLK = 0;
    localparam int B_GAIN_PATH = 1;
    localparam int B_BG_NEG = 2;
    localparam int B_CONV_PWR = 3;
    localparam int B_AMP_PWR = 4;
    localparam int B_BYPASS = 5;
    localparam int B_X10 = 6;
    localparam int B_X20 = 7;
    localparam int B_GND = 8;
    localparam int B_HOLD = 9;
    localparam int B_REF = 10;
    localparam int B_MUX3 = 11;
    localparam int B_MUX4 = 12;
    localparam int B_MUX5 = 13;
    localparam int B_MUX6 = 14;
    localparam int B_MUX7 = 15;
    localparam int B_DAC_LO = 16;

    // values after reset: the recommended idle inputs
    localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0220;
    localparam logic [DAC_W-1:0] DAC_RST = 10'h200;
    localparam logic [N_IN-1:0] IDLE_VEC = {DAC_RST, CTRL_RST};
    localparam logic [N_CELL-1:0] CELL_RST = {IDLE_VEC, 1'b0};

    // status register bits
    localparam int ST_COMP = 0;
    localparam int ST_EXTEST = 1;
    localparam int ST_COMP_RAW = 2;
    localparam int ST_SETTLED = 3;

    // synchroniser lanes
    localparam int S_TCK = 0;
    localparam int S_TDI = 1;
    localparam int S_CAP = 2;
    localparam int S_SHIFT = 3;
    localparam int S_UPD = 4;
    localparam int S_EXTEST = 5;
    localparam int S_COMP = 6;
    localparam int SYNC_W = 7;

    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_RESP = 1'b1
    } abc_apb_st_t;

endpackage

module abc_scan_reg
    import abc_pkg::*;
#(
    parameter int N = N_CELL,
    parameter logic [N-1:0] UPD_RST = '0
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // tck edge strobes, one cycle each, and the synced scan levels
    input wire logic tck_rise,
    input wire logic tck_fall,
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic tdi,
    // parallel side
    input wire logic [N-1:0] par_in,
    output logic scan_out,
    output logic [N-1:0] upd_out
);

    if (N < 2)
    begin : g_bad_width
        $error("abc_scan_reg needs at least two cells");
    end

    typedef struct packed {
        logic [N-1:0] shift_q;
        logic [N-1:0] upd_q;
        logic tdo;
    } abc_cell_st_t;

    abc_cell_st_t r;
    abc_cell_st_t r_nxt;

    always_comb
    begin
        r_nxt = r;
        if (tck_rise)
        begin
            if (capture)
            begin
                r_nxt.shift_q = par_in;
            end
            else if (shift)
            begin
                r_nxt.shift_q = {tdi, r.shift_q[N-1:1]};
            end
        end
        // tdo and the update stage move on the falling tck edge, as in a standard cell
        if (tck_fall)
        begin
            r_nxt.tdo = r.shift_q[0];
            if (update)
            begin
                r_nxt.upd_q = r.shift_q;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            r.shift_q <= UPD_RST;
            r.upd_q <= UPD_RST;
            r.tdo <= 1'b0;
        end
        else
        begin
            r <= r_nxt;
        end
    end

    assign scan_out = r.tdo;
    assign upd_out = r.upd_q;

endmodule

// ---- abc_top_asserts.sv ----
// Purpose: port checks for the converter scan cells
// Assumes: one clock domain, synchronous reset
// Notes: write-to-output checks hold only while extest has long been low
`timescale 1ns/1ps
module abc_top_asserts
    import abc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // scan
    input wire logic tck,
    input wire logic extest,
    input wire logic tdo,
    // converter
    input wire logic comp_in,
    input wire logic conv_power_on,
    input wire logic gain_bypass_sel,
    input wire logic hold,
    input wire logic [DAC_W-1:0] dac_code
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    wire logic acc = psel && penable && !pready;
    wire logic wdone = psel && penable && pready && pwrite && !extest;
    property p_idle;
        $fell(reset) |-> dac_code == 10'h200 && gain_bypass_sel && hold && !conv_power_on;
    endproperty
    a_idle: assert property (p_idle) else $error("outputs not idle after reset");
    property p_rdy;
        acc |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no answer one cycle after access");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_unmap;
        acc && paddr[7:2] > 6'h3 |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    property p_ctrl;
        wdone && paddr[7:2] == 6'h0 |-> ##2
            {hold, gain_bypass_sel, conv_power_on} == {$past(pwdata[9], 2),
            $past(pwdata[5], 2), $past(pwdata[3], 2)};
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control write not on pins");
    property p_dac;
        wdone && paddr[7:2] == 6'h1 |-> ##2 dac_code == $past(pwdata[9:0], 2);
    endproperty
    a_dac: assert property (p_dac) else $error("dac write not on pins");
    property p_comp;
        acc && !pwrite && paddr[7:2] == 6'h2 |=> prdata[2] == $past(comp_in, 3);
    endproperty
    a_comp: assert property (p_comp) else $error("raw comparator bit wrong");
    // tdo may only move in the low phase of tck, after the synced fall
    property p_tdo;
        $changed(tdo) |-> !tck;
    endproperty
    a_tdo: assert property (p_tdo) else $error("tdo moved while tck high");
    c_wr: cover property (psel && pready && pwrite);
    c_err: cover property (pslverr);
    c_tdo: cover property ($changed(tdo));
endmodule

bind abc_top abc_top_asserts i_chk (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tck, .extest, .tdo, .comp_in, .conv_power_on, .gain_bypass_sel,
    .hold, .dac_code);

// ---- abc_tester.sv ----
// Purpose: scan tester model on the test access port pins
// Assumes: tck stays high 5 clocks and low at least 10 clocks, above the synchroniser delay
// Notes: tck stands low between scans; tdi flips after a scan so no stale bit lingers
`timescale 1ns/1ps
module abc_tester
    import abc_pkg::*;
(
    // clock
    input wire logic clock,
    // tap pins
    output logic tck,
    output logic tdi,
    output logic capture_dr,
    output logic shift_dr,
    output logic update_dr,
    output logic extest,
    input wire logic tdo
);
    initial
    begin
        {tck, tdi, capture_dr, shift_dr, update_dr, extest} = 6'h00;
    end
    task automatic pulse(output logic s);
        repeat (5) @(posedge clock);
        s = tdo;
        tck <= 1'b1;
        repeat (5) @(posedge clock);
        tck <= 1'b0;
        repeat (5) @(posedge clock);
    endtask
    task automatic mode(input logic v);
        @(posedge clock);
        extest <= v;
        repeat (10) @(posedge clock);
    endtask
    // caller supplies vectors with aclk 0 and at most one negative source
    task automatic scan(input logic [N_CELL-1:0] din, output logic [N_CELL-1:0] dout);
        logic s;
        @(posedge clock);
        capture_dr <= 1'b1;
        pulse(s);
        capture_dr <= 1'b0;
        shift_dr <= 1'b1;
        for (int i = 0; i < N_CELL; i++)
        begin
            tdi <= din[i];
            pulse(dout[i]);
        end
        shift_dr <= 1'b0;
        update_dr <= 1'b1;
        pulse(s);
        update_dr <= 1'b0;
        tdi <= ~tdi;
    endtask
endmodule

// ---- abc_top_tb_top.sv ----
// Purpose: self-checking bench for the converter scan cells
// Assumes: apb master and scan tester both act just after rising edges
// Notes: expected values come from the idle values and the writes made here
`timescale 1ns/1ps
module abc_top_tb_top
    import abc_pkg::*;
;
    logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic comp_in = 1'b0, pready, pslverr, tck, tdi, capture_dr, shift_dr, update_dr, extest;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0, prdata, q;
    logic tdo, aclk, gain_path_en, bandgap_neg_en, conv_power_on, amp_power_on, gain_bypass_sel;
    logic gain_x10_en, gain_x20_en, neg_input_ground_en, hold, bandgap_ref_en, input_mux_sel_b3;
    logic input_mux_sel_b4, input_mux_sel_b5, input_mux_sel_b6, input_mux_sel_b7;
    logic [DAC_W-1:0] dac_code;
    logic [N_CELL-1:0] dout;
    int fails = 0, num_checks = 0;
    wire logic [15:0] ctl = {input_mux_sel_b7, input_mux_sel_b6, input_mux_sel_b5,
        input_mux_sel_b4, input_mux_sel_b3, bandgap_ref_en, hold, neg_input_ground_en,
        gain_x20_en, gain_x10_en, gain_bypass_sel, amp_power_on, conv_power_on,
        bandgap_neg_en, gain_path_en, aclk};
    always #10 clock = ~clock;
    abc_top i_dut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tck, .tdi, .capture_dr, .shift_dr, .update_dr, .extest, .tdo, .comp_in,
        .aclk, .gain_path_en, .bandgap_neg_en, .conv_power_on, .amp_power_on, .gain_bypass_sel,
        .gain_x10_en, .gain_x20_en, .neg_input_ground_en, .hold, .bandgap_ref_en,
        .input_mux_sel_b3, .input_mux_sel_b4, .input_mux_sel_b5, .input_mux_sel_b6,
        .input_mux_sel_b7, .dac_code);
    abc_tester i_tst (.clock, .tck, .tdi, .capture_dr, .shift_dr, .update_dr, .extest, .tdo);
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x)
        begin
            $display("[ERR] %s expected %h seen %h", n, x, g);
            fails++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        chk("resp", {30'h0, ee, 1'b1}, {30'h0, pslverr, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 1'b0);
        chk("prdata", x, q);
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        stop_test();
    end
    initial
    begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        chk("ctl", 32'h220, {16'h0, ctl});
        chk("dac", 32'h200, {22'h0, dac_code});
        rd(OFF_SCAN_UPD, 32'h0200_0220);
        rd(OFF_STATUS, 32'h0);
        $display("test reset done");
        for (int i = 0; i < CTRL_W; i++)
        begin
            apb(1'b1, OFF_CTRL, 32'hFFFF_0000 | (32'h1 << i), 1'b0);
            repeat (3) @(posedge clock);
            chk("ctl", 32'h1 << i, {16'h0, ctl});
            rd(OFF_CTRL, 32'h1 << i);
        end
        apb(1'b1, OFF_CTRL, 32'h220, 1'b0);
        apb(1'b1, OFF_DAC, 32'hFFFF_F123, 1'b0);
        repeat (3) @(posedge clock);
        chk("dac", 32'h123, {22'h0, dac_code});
        rd(OFF_DAC, 32'h123);
        apb(1'b0, 8'h10, 32'h0, 1'b1);
        chk("prdata", 32'h0, q);
        apb(1'b1, OFF_STATUS, 32'hF, 1'b0);
        rd(OFF_CTRL, 32'h220);
        $display("test registers done");
        comp_in <= 1'b1;
        repeat (5) @(posedge clock);
        rd(OFF_STATUS, 32'h5);
        apb(1'b1, OFF_CTRL, 32'h228, 1'b0);
        rd(OFF_STATUS, 32'h5);
        repeat (12) @(posedge clock);
        rd(OFF_STATUS, 32'hD);
        $display("test status done");
        i_tst.mode(1'b1);
        // hold low means sampling, so the code stays at midpoint
        i_tst.scan({10'h200, 16'h0008, 1'b1}, dout);
        chk("dout", {5'h0, 10'h123, 16'h0228, 1'b1}, {5'h0, dout});
        chk("ctl", 32'h008, {16'h0, ctl});
        chk("dac", 32'h200, {22'h0, dac_code});
        rd(OFF_SCAN_UPD, 32'h0200_0008);
        repeat (12) @(posedge clock);
        rd(OFF_STATUS, 32'hF);
        comp_in <= 1'b0;
        i_tst.scan({10'h200, 16'h0220, 1'b0}, dout);
        chk("dout", {5'h0, 10'h123, 16'h0228, 1'b0}, {5'h0, dout});
        chk("ctl", 32'h220, {16'h0, ctl});
        rd(OFF_STATUS, 32'h2);
        i_tst.mode(1'b0);
        chk("ctl", 32'h228, {16'h0, ctl});
        chk("dac", 32'h123, {22'h0, dac_code});
        $display("test scan done");
        // a second reset in mid-run must bring back the idle values
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        chk("ctl", 32'h220, {16'h0, ctl});
        chk("dac", 32'h200, {22'h0, dac_code});
        rd(OFF_CTRL, 32'h220);
        rd(OFF_DAC, 32'h200);
        $display("test reset again done");
        stop_test();
    end
endmodule
